/* File: logic/gwsb_status_bytes.v */
// Functional notes
// [RULE_01] Write ack bit 0 toggles per good command; two commands done in one cycle give a single toggle
// [RULE_02] Service bit 2 high while service selected
// [RULE_03] Data exist bit 3 follows buffer occupancy
// [RULE_04] Block ready bit 4 toggles per block move
// [RULE_05] Loss bit 5, overflow 6, new data 7
// [RULE_06] Status byte 1 holds following byte count
// [RULE_07] Data loss sticky until reset
// [RULE_08] Overflow self-clears; blocks serial request-to-send
// [RULE_09] New data toggles per data set sent in transparent mode
// [RULE_10] Bit 1 zero; all cleared at reset
`timescale 1ns/1ps
`default_nettype none
`include "gwsb_defines.vh"

module gwsb_status_bytes #(
	parameter LEN_WIDTH  = 8,
	parameter FILL_WIDTH = 11
) (
	// Clock and reset
	input  wire                  clk_sys,
	input  wire                  reset_n,
	// Command completion events
	input  wire                  copy_to_buffer_cmd_done,
	input  wire                  send_from_buffer_cmd_done,
	// Service switch
	input  wire                  service_gateway_position,
	input  wire                  end_device_service_position,
	// Ring buffer state and events
	input  wire [FILL_WIDTH-1:0] buffer_fill_level,
	input  wire                  buffer_overflow_event,
	input  wire                  data_dropped_event,
	input  wire                  data_truncated_event,
	// Input image update events
	input  wire                  block_moved_event,
	input  wire                  data_set_sent_event,
	input  wire                  transparent_mode,
	input  wire [LEN_WIDTH-1:0]  payload_length_in,
	// Status bytes toward the controller
	output wire [7:0]            gateway_status_flags,
	output wire [7:0]            payload_length_byte,
	// Serial handshake
	output wire                  serial_rts
);

	localparam [FILL_WIDTH-1:0] BUFFER_BYTES = `GWSB_BUFFER_BYTES;
	localparam [FILL_WIDTH-1:0] FILL_EMPTY   = {FILL_WIDTH{1'b0}};

	reg                  write_ack_toggle;
	reg                  service_mode_flag;
	reg                  data_exist_flag;
	reg                  block_ready_toggle;
	reg                  data_loss_flag;
	reg                  buffer_overflow_flag;
	reg                  new_data_toggle;
	reg [LEN_WIDTH-1:0]  payload_length_field;

	reg                  next_write_ack_toggle;
	reg                  next_service_mode_flag;
	reg                  next_data_exist_flag;
	reg                  next_block_ready_toggle;
	reg                  next_data_loss_flag;
	reg                  next_buffer_overflow_flag;
	reg                  next_new_data_toggle;
	reg [LEN_WIDTH-1:0]  next_payload_length_field;

	reg [7:0]            status_flags_word;

	wire                 write_done;
	wire                 service_selected;
	wire                 buffer_not_empty;
	wire                 space_free;
	wire                 loss_event;
	wire                 length_load;
	wire                 new_data_event;

	// Both commands in one cycle still give a single toggle
	assign write_done = copy_to_buffer_cmd_done |
		send_from_buffer_cmd_done;
	assign service_selected = service_gateway_position |
		end_device_service_position;
	assign buffer_not_empty = (buffer_fill_level != FILL_EMPTY);
	// Space is back once the fill drops below capacity
	assign space_free = (buffer_fill_level < BUFFER_BYTES);
	assign loss_event = data_dropped_event | data_truncated_event;
	// Block move and data set sent share one length load
	assign length_load = block_moved_event | data_set_sent_event;
	// Toggle only in transparent operation
	assign new_data_event = data_set_sent_event & transparent_mode;

	always @* begin
		next_write_ack_toggle = write_ack_toggle;
		if (write_done) begin
			next_write_ack_toggle = ~write_ack_toggle; // see [RULE_01]
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			write_ack_toggle <= 1'b0; // see [RULE_10]
		end else begin
			write_ack_toggle <= next_write_ack_toggle;
		end
	end

	always @* begin
		next_service_mode_flag = service_selected; // see [RULE_02]
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			service_mode_flag <= 1'b0;
		end else begin
			service_mode_flag <= next_service_mode_flag;
		end
	end

	always @* begin
		next_data_exist_flag = buffer_not_empty; // see [RULE_03]
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			data_exist_flag <= 1'b0;
		end else begin
			data_exist_flag <= next_data_exist_flag;
		end
	end

	always @* begin
		next_block_ready_toggle = block_ready_toggle;
		if (block_moved_event) begin
			next_block_ready_toggle = ~block_ready_toggle; // see [RULE_04]
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			block_ready_toggle <= 1'b0;
		end else begin
			block_ready_toggle <= next_block_ready_toggle;
		end
	end

	// Sticky: only reset clears it
	always @* begin
		next_data_loss_flag = data_loss_flag;
		if (loss_event) begin
			next_data_loss_flag = 1'b1; // see [RULE_07]
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			data_loss_flag <= 1'b0;
		end else begin
			data_loss_flag <= next_data_loss_flag;
		end
	end

	// Event wins over the automatic clear
	always @* begin
		next_buffer_overflow_flag = buffer_overflow_flag;
		if (buffer_overflow_event) begin
			next_buffer_overflow_flag = 1'b1; // see [RULE_08]
		end else if (space_free) begin
			next_buffer_overflow_flag = 1'b0; // see [RULE_08]
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			buffer_overflow_flag <= 1'b0;
		end else begin
			buffer_overflow_flag <= next_buffer_overflow_flag;
		end
	end

	always @* begin
		next_new_data_toggle = new_data_toggle;
		if (new_data_event) begin
			next_new_data_toggle = ~new_data_toggle; // see [RULE_09]
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			new_data_toggle <= 1'b0;
		end else begin
			new_data_toggle <= next_new_data_toggle;
		end
	end

	always @* begin
		next_payload_length_field = payload_length_field;
		if (length_load) begin
			next_payload_length_field = payload_length_in; // see [RULE_06]
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			payload_length_field <= `GWSB_LENGTH_RESET;
		end else begin
			payload_length_field <= next_payload_length_field;
		end
	end

	always @* begin
		status_flags_word = `GWSB_FLAGS_RESET;
		status_flags_word[`GWSB_WRITE_ACK_BIT] = write_ack_toggle;
		status_flags_word[`GWSB_UNUSED_BIT] = 1'b0; // see [RULE_10]
		status_flags_word[`GWSB_SERVICE_MODE_BIT] = service_mode_flag;
		status_flags_word[`GWSB_DATA_EXIST_BIT] = data_exist_flag;
		status_flags_word[`GWSB_BLOCK_READY_BIT] = block_ready_toggle;
		status_flags_word[`GWSB_DATA_LOSS_BIT] = data_loss_flag;
		status_flags_word[`GWSB_OVERFLOW_BIT] = buffer_overflow_flag;
		status_flags_word[`GWSB_NEW_DATA_BIT] = new_data_toggle; // see [RULE_05]
	end

	assign gateway_status_flags = status_flags_word;
	assign payload_length_byte = payload_length_field;
	// Stall the serial sender from an overflow event until the fill drops below capacity
	assign serial_rts = ~buffer_overflow_flag; // see [RULE_08]

endmodule

`default_nettype wire

/* File: logic/gwsb_defines.vh */
`ifndef GWSB_DEFINES_VH
`define GWSB_DEFINES_VH

// Status byte 0 bit positions
`define GWSB_WRITE_ACK_BIT      0
`define GWSB_UNUSED_BIT         1
`define GWSB_SERVICE_MODE_BIT   2
`define GWSB_DATA_EXIST_BIT     3
`define GWSB_BLOCK_READY_BIT    4
`define GWSB_DATA_LOSS_BIT      5
`define GWSB_OVERFLOW_BIT       6
`define GWSB_NEW_DATA_BIT       7

// Reset values
`define GWSB_FLAGS_RESET        8'h00
`define GWSB_LENGTH_RESET       8'h00

// Buffer capacity in bytes (1 kByte)
`define GWSB_BUFFER_BYTES       11'h400

`endif

/* File: dv/gwsb_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gwsb_defines.vh"
module gwsb_props #(parameter FILL_WIDTH = 11, parameter LEN_WIDTH = 8)
	(input wire logic clk_sys, reset_n, copy_to_buffer_cmd_done,
	send_from_buffer_cmd_done, service_gateway_position,
	end_device_service_position, buffer_overflow_event, data_dropped_event,
	data_truncated_event, block_moved_event, data_set_sent_event,
	transparent_mode, serial_rts,
	input wire logic [FILL_WIDTH-1:0] buffer_fill_level,
	input wire logic [LEN_WIDTH-1:0] payload_length_in,
	input wire logic [7:0] gateway_status_flags, payload_length_byte);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire [7:0] f = gateway_status_flags;
	property p_wa; copy_to_buffer_cmd_done|send_from_buffer_cmd_done
		|=> f[0]!=$past(f[0]); endproperty
	a_wa: assert property(p_wa) else $error("ack");
	property p_sm; 1 |=> f[2]==$past(service_gateway_position|
		end_device_service_position); endproperty
	a_sm: assert property(p_sm) else $error("svc");
	property p_dx; 1 |=> f[3]==($past(buffer_fill_level)!=0); endproperty
	a_dx: assert property(p_dx) else $error("dex");
	property p_br; block_moved_event |=> f[4]!=$past(f[4]); endproperty
	a_br: assert property(p_br) else $error("blk");
	property p_ln; block_moved_event|data_set_sent_event
		|=> payload_length_byte==$past(payload_length_in); endproperty
	a_ln: assert property(p_ln) else $error("len");
	property p_dl; data_dropped_event|data_truncated_event|f[5]
		|=> f[5]; endproperty
	a_dl: assert property(p_dl) else $error("loss");
	property p_bo; buffer_overflow_event |=> f[6]&&!serial_rts; endproperty
	a_bo: assert property(p_bo) else $error("ovf");
	property p_bc; !buffer_overflow_event &&
		buffer_fill_level < `GWSB_BUFFER_BYTES |=> !f[6] && serial_rts;
	endproperty
	a_bc: assert property(p_bc) else $error("ovf clr");
	property p_nd; data_set_sent_event&&transparent_mode
		|=> f[7]!=$past(f[7]); endproperty
	a_nd: assert property(p_nd) else $error("nd");
	property p_ns; !(data_set_sent_event&&transparent_mode)
		|=> f[7]==$past(f[7]); endproperty
	a_ns: assert property(p_ns) else $error("nd hold");
	property p_z; !f[1] && serial_rts!=f[6]; endproperty
	a_z: assert property(p_z) else $error("bit1");
	c_ov: cover property(f[6]);
	c_dl: cover property(f[5]);
	c_nd: cover property(f[7]);
	c_sm: cover property(f[2]);
endmodule
bind gwsb_status_bytes gwsb_props #(.FILL_WIDTH(FILL_WIDTH),
	.LEN_WIDTH(LEN_WIDTH)) u_props(.clk_sys(clk_sys), .reset_n(reset_n),
	.copy_to_buffer_cmd_done(copy_to_buffer_cmd_done),
	.send_from_buffer_cmd_done(send_from_buffer_cmd_done),
	.service_gateway_position(service_gateway_position),
	.end_device_service_position(end_device_service_position),
	.buffer_overflow_event(buffer_overflow_event),
	.data_dropped_event(data_dropped_event),
	.data_truncated_event(data_truncated_event),
	.block_moved_event(block_moved_event),
	.data_set_sent_event(data_set_sent_event),
	.transparent_mode(transparent_mode), .serial_rts(serial_rts),
	.buffer_fill_level(buffer_fill_level),
	.payload_length_in(payload_length_in),
	.gateway_status_flags(gateway_status_flags),
	.payload_length_byte(payload_length_byte));
`default_nettype wire

/* File: dv/gwsb_plc.sv */
`timescale 1ns/1ps
`default_nettype none
module gwsb_plc(input wire logic clk_sys,input wire logic [7:0] flags,len,
	output logic [15:0] image);
	// Controller polls the input image every cycle
	always @(posedge clk_sys) image <= {len,flags};
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys=0, reset_n=0;
	logic [9:0] ev=0;
	logic [10:0] fill=0;
	logic [7:0] len=0, st, lb;
	logic [15:0] image;
	logic rts;
	int errors=0, samples_checked=0;
	always #10 clk_sys=~clk_sys;
	gwsb_status_bytes DUT(.clk_sys, .reset_n,
		.copy_to_buffer_cmd_done(ev[0]), .send_from_buffer_cmd_done(ev[1]),
		.service_gateway_position(ev[2]), .end_device_service_position(ev[3]),
		.buffer_overflow_event(ev[4]), .data_dropped_event(ev[5]),
		.data_truncated_event(ev[6]), .block_moved_event(ev[7]),
		.data_set_sent_event(ev[8]), .transparent_mode(ev[9]),
		.buffer_fill_level(fill), .payload_length_in(len),
		.gateway_status_flags(st), .payload_length_byte(lb), .serial_rts(rts));
	gwsb_plc PLC(.clk_sys, .flags(st), .len(lb), .image);
	task chk(input [15:0] x); begin
		samples_checked++;
		if (image!==x) begin
			errors++;
			$display("mismatch %0t %h %h", $time, image, x);
		end
	end endtask
	task chk_rts(input x); begin
		samples_checked++;
		if (rts!==x) begin
			errors++;
			$display("mismatch %0t %h %h", $time, rts, x);
		end
	end endtask
	// Pulses last one cycle; switch and mode levels are kept
	task p(input [9:0] v, input [10:0] fl, input [7:0] l, input [15:0] x);
	begin
		ev = v;
		fill = fl;
		len = l;
		@(negedge clk_sys);
		ev = v & 10'h20c;
		@(negedge clk_sys);
		chk(x);
	end endtask
	task wrap_up; begin
		$display("errors %0d checked %0d", errors, samples_checked);
		if (errors==0 && samples_checked>0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end endtask
	task s_ack; begin
		p(10'h003, 11'h000, 8'h00, 16'h0001);
		p(10'h001, 11'h000, 8'h00, 16'h0000);
		p(10'h002, 11'h000, 8'h00, 16'h0001);
		p(10'h002, 11'h000, 8'h00, 16'h0000);
	end endtask
	task s_len; begin
		p(10'h080, 11'h000, 8'h05, 16'h0510);
		p(10'h100, 11'h000, 8'h09, 16'h0910);
		p(10'h300, 11'h000, 8'h07, 16'h0790);
	end endtask
	task s_flg; begin
		p(10'h240, 11'h000, 8'h07, 16'h07b0);
		p(10'h220, 11'h000, 8'h07, 16'h07b0);
		p(10'h210, 11'h400, 8'h07, 16'h07f8);
		chk_rts(1'b0);
		p(10'h200, 11'h000, 8'h07, 16'h07b0);
		chk_rts(1'b1);
		p(10'h210, 11'h005, 8'h07, 16'h07f8);
		chk_rts(1'b1);
		p(10'h208, 11'h000, 8'h07, 16'h07b4);
		p(10'h200, 11'h000, 8'h07, 16'h07b0);
		p(10'h204, 11'h000, 8'h07, 16'h07b4);
		p(10'h200, 11'h000, 8'h07, 16'h07b0);
	end endtask
	initial begin
		repeat(6) @(posedge clk_sys);
		@(negedge clk_sys);
		reset_n = 1;
		chk(16'h0000);
		chk_rts(1'b1);
		s_ack;
		s_len;
		s_flg;
		reset_n = 0;
		@(negedge clk_sys);
		reset_n = 1;
		@(negedge clk_sys);
		chk(16'h0000);
		chk_rts(1'b1);
		p(10'h020, 11'h000, 8'h00, 16'h0020);
		wrap_up;
	end
	initial begin
		#100000; errors++; wrap_up;
	end
endmodule
`default_nettype wire
